/* File: hdl/twmsc_ctrl.sv */
// Purpose: two-wire bus master built from software segments
// Assumes: 10 MHz clk, pins open-drain with external pull-ups
// Notes: one segment at a time; no arbitration, single master only
`timescale 1ns/1ns
`include "twmsc_map.svh"

// Functional notes
// - master runs only when mode field is 3
// - master only, no arbitration performed
// - supports 100 kbps and 400 kbps rates
// - rate is 12 MHz over (lin+1)*2^exp
// - exactly one command bit set per segment
// - receive acknowledge follows the acknowledge select bit
// - bytes exchanged through the data register
// - start/stop clear command bit, set command-finished
// - transmit shifts data, clears bit, sets finished
// - receive loads data unless a byte is unread, clears bit, sets finished
// - status keeps slave acknowledge or negative acknowledge
// - events on rising edges of finished flags
// - event on transmitted byte answered with NACK
// - receive overrun and transmit underrun events
// - interrupt needs second and top level enables
// - lines driven low only, read back always
module twmsc_ctrl
  import twmsc_pkg::*;
#(
  parameter int ACC_W = 26
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic top_level_serial_irq_en,
  output logic irq
);

  twmsc_state_t s_q; // Registered state
  twmsc_state_t s_d; // Next state
  logic qtick; // One quarter of a bit period elapsed

  // True when exactly one of the four command bits is set
  function automatic logic one_hot4(input logic [3:0] c);
    return (c == 4'h1) || (c == 4'h2) || (c == 4'h4) || (c == 4'h8);
  endfunction : one_hot4

  // Reset image of the whole state
  function automatic twmsc_state_t rst_state();
    twmsc_state_t r;
    r = '0;
    r.mode = `TWMSC_MODE_RST;
    r.lin = `TWMSC_LIN_RST;
    r.expo = `TWMSC_EXP_RST;
    r.cmd = `TWMSC_CMD_RST;
    r.irq_en = `TWMSC_IEN_RST;
    r.seg = TWMSC_SEG_IDLE;
    return r;
  endfunction : rst_state

  // Quarter-phase timing runs only while a segment is in progress
  twmsc_qdiv #(
    .LIN_W(4),
    .EXP_W(4),
    .ACC_W(ACC_W)
  ) u_qdiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(s_q.seg != TWMSC_SEG_IDLE),
    .lin(s_q.lin),
    .expo(s_q.expo),
    .qtick(qtick)
  );

  // Register access, segment sequencing and event capture
  always_comb
  begin
    logic tw_on;
    logic done;
    tw_on = (s_q.mode == `TWMSC_MODE_TWI);
    done = 1'b0;
    s_d = s_q;

    // Pin synchronisers; first stage feeds only the second
    s_d.sda_s1 = sda_i;
    s_d.sda_s2 = s_q.sda_s1;
    s_d.scl_s1 = scl_i;
    s_d.scl_s2 = s_q.scl_s1;

    // Open-drain: the driven level is always low; no arbitration sensing
    s_d.sda_o = 1'b0;
    s_d.scl_o = 1'b0;

    // Read data stand one cycle after the strobe, zero otherwise
    s_d.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `TWMSC_MODE_OFS: s_d.rdata = {6'h00, s_q.mode};
        `TWMSC_LIN_OFS: s_d.rdata = {4'h0, s_q.lin};
        `TWMSC_EXP_OFS: s_d.rdata = {4'h0, s_q.expo};
        `TWMSC_CMD_OFS: s_d.rdata = {4'h0, s_q.cmd};
        `TWMSC_ACK_OFS: s_d.rdata = {7'h00, s_q.ack_sel};
        `TWMSC_DATA_OFS:
        begin
          // Reading the received byte frees the data register
          s_d.rdata = s_q.data;
          s_d.rx_full = 1'b0;
        end
        `TWMSC_STAT_OFS: s_d.rdata = {4'h0, s_q.stat};
        `TWMSC_IEN_OFS: s_d.rdata = {2'h0, s_q.irq_en};
        `TWMSC_IFLAG_OFS: s_d.rdata = {2'h0, s_q.irq_flag};
        default: s_d.rdata = 8'h00; // Unmapped reads return zero
      endcase
    end

    // Software writes; clears come first so hardware sets win below
    if (reg_wr)
    begin
      case (reg_addr)
        `TWMSC_MODE_OFS: s_d.mode = reg_wdata[1:0];
        `TWMSC_LIN_OFS: s_d.lin = reg_wdata[3:0];
        `TWMSC_EXP_OFS: s_d.expo = reg_wdata[3:0];
        `TWMSC_CMD_OFS:
        begin
          // Commands are taken only between segments
          if (s_q.seg == TWMSC_SEG_IDLE)
            s_d.cmd = reg_wdata[3:0];
        end
        `TWMSC_ACK_OFS: s_d.ack_sel = reg_wdata[0];
        `TWMSC_DATA_OFS:
        begin
          // Byte for the next transmit segment
          s_d.data = reg_wdata;
          s_d.tx_valid = 1'b1;
        end
        `TWMSC_STAT_OFS: s_d.stat = s_q.stat & ~reg_wdata[3:0];
        `TWMSC_IEN_OFS: s_d.irq_en = reg_wdata[5:0];
        `TWMSC_IFLAG_OFS: s_d.irq_flag = s_q.irq_flag & ~reg_wdata[5:0];
        default: ; // Unmapped writes are ignored
      endcase
    end

    // Segment engine
    if (!tw_on)
    begin
      // Other modes leave the bus alone and abandon any segment
      s_d.seg = TWMSC_SEG_IDLE;
      s_d.sda_oe = 1'b0;
      s_d.scl_oe = 1'b0;
    end
    else if (s_q.seg == TWMSC_SEG_IDLE)
    begin
      // Illegal combinations simply never start
      if (one_hot4(s_q.cmd))
      begin
        s_d.bitcnt = 4'h0;
        s_d.qph = 2'h0;
        s_d.shreg = s_q.data;
        if (s_q.cmd[`TWMSC_CMD_START])
          s_d.seg = TWMSC_SEG_START;
        else if (s_q.cmd[`TWMSC_CMD_SEND])
        begin
          s_d.seg = TWMSC_SEG_SEND;
          s_d.tx_valid = 1'b0;
          // Sending with no data write since the last send; hardware only sets
          if (!s_q.tx_valid)
            s_d.irq_flag[`TWMSC_IRQ_TXUND] = 1'b1;
        end
        else if (s_q.cmd[`TWMSC_CMD_RECV])
          s_d.seg = TWMSC_SEG_RECV;
        else
          s_d.seg = TWMSC_SEG_STOP;
      end
    end
    else if (qtick)
    begin
      case (s_q.qph)
        2'h0:
        begin
          // Pull the clock low before touching data
          s_d.scl_oe = 1'b1;
          s_d.qph = 2'h1;
        end
        2'h1:
        begin
          // Set up data while the clock is low
          case (s_q.seg)
            TWMSC_SEG_START: s_d.sda_oe = 1'b0;
            TWMSC_SEG_STOP: s_d.sda_oe = 1'b1;
            TWMSC_SEG_SEND:
              s_d.sda_oe = (s_q.bitcnt < 4'h8) ? !s_q.shreg[7] : 1'b0;
            TWMSC_SEG_RECV:
              s_d.sda_oe = (s_q.bitcnt < 4'h8) ? 1'b0 : s_q.ack_sel;
            default: s_d.sda_oe = 1'b0;
          endcase
          s_d.qph = 2'h2;
        end
        2'h2:
        begin
          // Release the clock; pull-ups raise it
          s_d.scl_oe = 1'b0;
          s_d.qph = 2'h3;
        end
        default:
        begin
          // A slave holding the clock low stretches this quarter
          if (s_q.scl_s2)
          begin
            s_d.qph = 2'h0;
            case (s_q.seg)
              TWMSC_SEG_START:
              begin
                // Data falls while the clock is high
                s_d.sda_oe = 1'b1;
                s_d.cmd[`TWMSC_CMD_START] = 1'b0;
                s_d.stat[`TWMSC_ST_CMDFIN] = 1'b1;
                done = 1'b1;
              end
              TWMSC_SEG_STOP:
              begin
                // Data rises while the clock is high
                s_d.sda_oe = 1'b0;
                s_d.cmd[`TWMSC_CMD_STOP] = 1'b0;
                s_d.stat[`TWMSC_ST_CMDFIN] = 1'b1;
                done = 1'b1;
              end
              TWMSC_SEG_SEND:
              begin
                if (s_q.bitcnt < 4'h8)
                begin
                  s_d.shreg = {s_q.shreg[6:0], 1'b0};
                  s_d.bitcnt = s_q.bitcnt + 4'h1;
                end
                else
                begin
                  // Ninth clock: high data means no acknowledge
                  s_d.stat[`TWMSC_ST_NACK] = s_q.sda_s2;
                  if (s_q.sda_s2)
                    s_d.irq_flag[`TWMSC_IRQ_NACK] = 1'b1;
                  s_d.cmd[`TWMSC_CMD_SEND] = 1'b0;
                  s_d.stat[`TWMSC_ST_TXFIN] = 1'b1;
                  done = 1'b1;
                end
              end
              TWMSC_SEG_RECV:
              begin
                if (s_q.bitcnt < 4'h8)
                begin
                  s_d.shreg = {s_q.shreg[6:0], s_q.sda_s2};
                  s_d.bitcnt = s_q.bitcnt + 4'h1;
                end
                else
                begin
                  // An unread byte is kept; the new one is lost
                  if (s_d.rx_full)
                    s_d.irq_flag[`TWMSC_IRQ_RXOVF] = 1'b1;
                  else
                  begin
                    s_d.data = s_q.shreg;
                    s_d.rx_full = 1'b1;
                  end
                  s_d.cmd[`TWMSC_CMD_RECV] = 1'b0;
                  s_d.stat[`TWMSC_ST_RXFIN] = 1'b1;
                  done = 1'b1;
                end
              end
              default: done = 1'b1;
            endcase
          end
        end
      endcase
    end
    if (done)
      s_d.seg = TWMSC_SEG_IDLE;

    // Finished flags raise events only on their rising edge
    if (s_d.stat[`TWMSC_ST_CMDFIN] && !s_q.stat[`TWMSC_ST_CMDFIN])
      s_d.irq_flag[`TWMSC_IRQ_CMDFIN] = 1'b1;
    if (s_d.stat[`TWMSC_ST_TXFIN] && !s_q.stat[`TWMSC_ST_TXFIN])
      s_d.irq_flag[`TWMSC_IRQ_TXFIN] = 1'b1;
    if (s_d.stat[`TWMSC_ST_RXFIN] && !s_q.stat[`TWMSC_ST_RXFIN])
      s_d.irq_flag[`TWMSC_IRQ_RXFIN] = 1'b1;

    // Both enable levels must agree before the processor is told
    s_d.irq = top_level_serial_irq_en && |(s_d.irq_flag & s_q.irq_en);
  end

  // State register; asynchronous reset to constants only
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= rst_state();
    else
      s_q <= s_d;
  end

  // Every output straight from the state register
  assign reg_rdata = s_q.rdata;
  assign sda_o = s_q.sda_o;
  assign sda_oe = s_q.sda_oe;
  assign scl_o = s_q.scl_o;
  assign scl_oe = s_q.scl_oe;
  assign irq = s_q.irq;

endmodule : twmsc_ctrl

/* File: hdl/twmsc_map.svh */
// Purpose: register offsets, field positions, reset values and rates for the
//   two-wire master segment controller
// Assumes: byte addresses on an 8-bit register port, one register per word
// Notes: definitions only
`ifndef TWMSC_MAP_SVH
`define TWMSC_MAP_SVH

// Register byte offsets
`define TWMSC_MODE_OFS 8'h00
`define TWMSC_LIN_OFS 8'h04
`define TWMSC_EXP_OFS 8'h08
`define TWMSC_CMD_OFS 8'h0C
`define TWMSC_ACK_OFS 8'h10
`define TWMSC_DATA_OFS 8'h14
`define TWMSC_STAT_OFS 8'h18
`define TWMSC_IEN_OFS 8'h1C
`define TWMSC_IFLAG_OFS 8'h20

// Controller mode value that selects the two-wire master
`define TWMSC_MODE_TWI 2'h3

// Segment command bits
`define TWMSC_CMD_START 0
`define TWMSC_CMD_SEND 1
`define TWMSC_CMD_RECV 2
`define TWMSC_CMD_STOP 3

// Status bits
`define TWMSC_ST_NACK 0
`define TWMSC_ST_TXFIN 1
`define TWMSC_ST_RXFIN 2
`define TWMSC_ST_CMDFIN 3

// Interrupt event bits
`define TWMSC_IRQ_CMDFIN 0
`define TWMSC_IRQ_TXFIN 1
`define TWMSC_IRQ_RXFIN 2
`define TWMSC_IRQ_NACK 3
`define TWMSC_IRQ_RXOVF 4
`define TWMSC_IRQ_TXUND 5

// Reset values
`define TWMSC_MODE_RST 2'h0
`define TWMSC_LIN_RST 4'h0
`define TWMSC_EXP_RST 4'h0
`define TWMSC_CMD_RST 4'h0
`define TWMSC_IEN_RST 6'h00

// Divider reference and system clock, in MHz
`define TWMSC_REF_MHZ 12
`define TWMSC_CLK_MHZ 10
// Quarter phases per serial clock period
`define TWMSC_QUARTERS 4

`endif

/* File: hdl/twmsc_pkg.sv */
// Purpose: types shared by the two-wire master segment controller
// Assumes: widths as in twmsc_map.svh
// Notes: state of the main module is one packed struct
package twmsc_pkg;

  // Segment being carried out
  typedef enum logic [2:0] {
    TWMSC_SEG_IDLE = 3'b000,
    TWMSC_SEG_START = 3'b001,
    TWMSC_SEG_SEND = 3'b010,
    TWMSC_SEG_RECV = 3'b011,
    TWMSC_SEG_STOP = 3'b100
  } twmsc_seg_t;

  // Complete state of the controller
  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] lin;
    logic [3:0] expo;
    logic [3:0] cmd;
    logic ack_sel;
    logic [7:0] data;
    logic tx_valid;
    logic rx_full;
    logic [3:0] stat;
    logic [5:0] irq_en;
    logic [5:0] irq_flag;
    logic [7:0] rdata;
    twmsc_seg_t seg;
    logic [3:0] bitcnt;
    logic [1:0] qph;
    logic [7:0] shreg;
    logic sda_oe;
    logic scl_oe;
    logic sda_o;
    logic scl_o;
    logic sda_s1;
    logic sda_s2;
    logic scl_s1;
    logic scl_s2;
    logic irq;
  } twmsc_state_t;

endpackage : twmsc_pkg

/* File: hdl/twmsc_qdiv.sv */
// Purpose: quarter-phase tick generator for the serial clock
// Assumes: clk at TWMSC_CLK_MHZ, rate defined against TWMSC_REF_MHZ
// Notes: fractional accumulator, so the average rate is exact
`timescale 1ns/1ns
`include "twmsc_map.svh"
module twmsc_qdiv
#(
  parameter int LIN_W = 4,
  parameter int EXP_W = 4,
  parameter int ACC_W = 26
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [LIN_W-1:0] lin,
  input wire logic [EXP_W-1:0] expo,
  output logic qtick
);

  // Largest divisor times the clock rate must fit the accumulator
  if (ACC_W < LIN_W + (1 << EXP_W) + 5)
  begin : g_chk
    $error("twmsc_qdiv: ACC_W too small for LIN_W and EXP_W");
  end

  // Whole state of the divider
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic tick;
  } twmsc_div_t;

  twmsc_div_t s_q; // Registered state
  twmsc_div_t s_d; // Next state

  // Reference cycles per serial clock period scaled by the clock rate
  function automatic logic [ACC_W-1:0] qlimit(input logic [LIN_W-1:0] l,
                                              input logic [EXP_W-1:0] e);
    logic [ACC_W-1:0] n;
    n = ACC_W'({1'b0, l} + (LIN_W+1)'(1)) << e;
    return ACC_W'(`TWMSC_CLK_MHZ) * n;
  endfunction : qlimit

  // Each clock adds quarters times reference ticks; wrap gives one quarter
  always_comb
  begin
    logic [ACC_W-1:0] nxt;
    nxt = s_q.acc + ACC_W'(`TWMSC_QUARTERS * `TWMSC_REF_MHZ);
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run)
    begin
      // Restart from zero so each segment starts with a full quarter
      s_d.acc = '0;
    end
    else if (nxt >= qlimit(lin, expo))
    begin
      s_d.acc = nxt - qlimit(lin, expo);
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.acc = nxt;
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign qtick = s_q.tick;

endmodule : twmsc_qdiv

/* File: sim/twmsc_ctrl_properties.sv */
// Purpose: port-level checks of the segment controller
// Assumes: register map of twmsc_map.svh, one clock domain
// Notes: shadows track bus writes only, not hardware clears
`timescale 1ns/1ns
`include "twmsc_map.svh"
module twmsc_ctrl_properties
(
  input logic clk,
  input logic sys_rst,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic sda_i,
  input logic sda_o,
  input logic sda_oe,
  input logic scl_i,
  input logic scl_o,
  input logic scl_oe,
  input logic top_level_serial_irq_en,
  input logic irq
);
  logic [1:0] mode_q; // Shadow of mode field
  logic [5:0] ien_q; // Shadow of event enables
  logic [3:0] cmd_w; // Last command written
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Shadows follow software writes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_q <= 2'h0;
      ien_q <= 6'h00;
      cmd_w <= 4'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `TWMSC_MODE_OFS: mode_q <= reg_wdata[1:0];
        `TWMSC_IEN_OFS: ien_q <= reg_wdata[5:0];
        `TWMSC_CMD_OFS: cmd_w <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end
  property p_rd_only;
    reg_rdata != 8'h00 |-> $past(reg_rd);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data outside read");
  property p_unmapped;
    reg_rd && (reg_addr > 8'h20 || reg_addr[1:0] != 2'h0) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_od_low;
    sda_o == 1'b0 && scl_o == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("line driven high");
  property p_mode_off;
    (mode_q != 2'h3) [*3] |-> !scl_oe && !sda_oe;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("bus active outside mode");
  property p_mode_rb;
    reg_rd && reg_addr == `TWMSC_MODE_OFS |=> reg_rdata == {6'h00, mode_q};
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
  property p_irq_src;
    irq |-> $past(top_level_serial_irq_en) && $past(ien_q) != 6'h00;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without enables");
  property p_irq_clr;
    reg_wr && reg_addr == `TWMSC_IFLAG_OFS && reg_wdata[5:0] == 6'h3F |-> ##2 !irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq after flag clear");
  // Data may move under a high clock only as start or stop
  property p_edge;
    $changed(sda_oe) && !scl_oe |-> cmd_w == 4'h1 || cmd_w == 4'h8;
  endproperty
  a_edge: assert property (p_edge) else $error("data moved under high clock");
endmodule : twmsc_ctrl_properties
bind twmsc_ctrl twmsc_ctrl_properties u_prop (.clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .sda_i, .sda_o, .sda_oe, .scl_i, .scl_o, .scl_oe,
  .top_level_serial_irq_en, .irq);

/* File: sim/twmsc_slave_model.sv */
// Purpose: behavioural two-wire slave for the bench
// Assumes: lines resolved by the bench, released lines read high
// Notes: bit count restarts at each start condition
`timescale 1ns/1ns
module twmsc_slave_model
(
  input logic scl,
  input logic sda,
  input logic reading, // Drive rd_byte in master receive
  input logic [7:0] rd_byte,
  input logic ack_en, // Acknowledge written bytes
  input logic stretch, // Hold clock low after each fall
  output logic sda_pull = 1'b0,
  output logic scl_pull = 1'b0,
  output logic [7:0] got_byte = 8'h00,
  output logic ack_seen = 1'b0
);
  logic [3:0] cnt = 4'h0; // Clock rises within the byte
  // Sample data and the ninth bit on the rise
  always @(posedge scl)
  begin
    if (cnt < 4'd8)
      got_byte = {got_byte[6:0], sda};
    else
      ack_seen = !sda;
    cnt = (cnt == 4'd8) ? 4'd0 : cnt + 4'd1;
  end
  // Start condition realigns the byte
  always @(negedge sda)
    if (scl)
      cnt = 4'd0;
  // Change data only while the clock is low
  always @(negedge scl)
  begin
    if (reading)
      sda_pull = cnt < 4'd8 && !rd_byte[3'd7 - cnt[2:0]];
    else
      sda_pull = cnt == 4'd8 && ack_en;
    if (stretch)
    begin
      scl_pull = 1'b1;
      #3000;
      scl_pull = 1'b0;
    end
  end
endmodule : twmsc_slave_model

/* File: sim/twmsc_ctrl_test.sv */
// Purpose: register-level bench of the segment controller
// Assumes: 10 MHz clock, slave model with pull-ups
// Notes: every wait is bounded, either a fixed cycle count or a bounded poll
`timescale 1ns/1ns
`include "twmsc_map.svh"
module twmsc_ctrl_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic top_en = 1'b0;
  logic reading = 1'b0;
  logic ack_en = 1'b0;
  logic stretch = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] reg_rdata, got_byte;
  logic sda_o, sda_oe, scl_o, scl_oe, irq, sda_pull, scl_pull, ack_seen;
  wire sda = !(sda_oe | sda_pull); // Pull-up wins when released
  wire scl = !(scl_oe | scl_pull);
  int n_mismatch = 0;
  int n_compared = 0;
  int n_rise = 0;
  int i;
  time t1, t9;
  logic [3:0] lins [3] = '{4'd14, 4'd15, 4'd14};
  logic [3:0] exps [3] = '{4'd3, 4'd1, 4'd1};
  logic [7:0] abytes [3] = '{8'hF2, 8'h34, 8'hA4};
  always #50 clk = ~clk;
  // Time the first and ninth clock rise of a byte
  always @(posedge scl)
  begin
    n_rise = n_rise + 1;
    if (n_rise == 1)
      t1 = $time;
    if (n_rise == 9)
      t9 = $time;
  end
  twmsc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .top_level_serial_irq_en(top_en), .irq(irq));
  twmsc_slave_model slave (.scl(scl), .sda(sda), .reading(reading),
    .rd_byte(rd_byte), .ack_en(ack_en), .stretch(stretch), .sda_pull(sda_pull),
    .scl_pull(scl_pull), .got_byte(got_byte), .ack_seen(ack_seen));
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Times may differ by synchroniser and fractional tick jitter
  task automatic chk_t(input time g, input time e);
    n_compared++;
    if (g > e + 300 || g + 300 < e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_t
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk
  // Issue one segment and poll until its bit clears
  task automatic seg(input logic [7:0] c);
    logic [7:0] d;
    int k;
    wr(`TWMSC_CMD_OFS, c);
    for (k = 0; k < 4000; k++)
    begin
      rd(`TWMSC_CMD_OFS, d);
      if (d === 8'h00)
        break;
    end
    if (k == 4000)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask : seg
  // Check status and event flags, then clear both
  task automatic fin(input logic [7:0] s, input logic [7:0] f);
    rchk(`TWMSC_STAT_OFS, s);
    rchk(`TWMSC_IFLAG_OFS, f);
    wr(`TWMSC_STAT_OFS, 8'h0F);
    wr(`TWMSC_IFLAG_OFS, 8'h3F);
  endtask : fin
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 10; i++)
      rchk(8'(i * 4), 8'h00);
    wr(`TWMSC_CMD_OFS, 8'h01);
    repeat (40) @(posedge clk);
    rchk(`TWMSC_CMD_OFS, 8'h01);
    wr(`TWMSC_CMD_OFS, 8'h00);
    wr(`TWMSC_MODE_OFS, 8'h03);
    rchk(`TWMSC_MODE_OFS, 8'h03);
    wr(`TWMSC_LIN_OFS, 8'h03);
    wr(`TWMSC_EXP_OFS, 8'h01);
    wr(`TWMSC_CMD_OFS, 8'h03);
    repeat (40) @(posedge clk);
    rchk(`TWMSC_CMD_OFS, 8'h03);
    rchk(`TWMSC_STAT_OFS, 8'h00);
    wr(`TWMSC_CMD_OFS, 8'h00);
    wr(`TWMSC_IEN_OFS, 8'h3F);
    top_en <= 1'b1;
    seg(8'h01);
    chk({7'h00, irq}, 8'h01);
    top_en <= 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    top_en <= 1'b1;
    fin(8'h08, 8'h01);
    wr(`TWMSC_DATA_OFS, 8'hA4);
    ack_en <= 1'b1;
    seg(8'h02);
    chk(got_byte, 8'hA4);
    fin(8'h02, 8'h02);
    seg(8'h02);
    fin(8'h02, 8'h22);
    wr(`TWMSC_DATA_OFS, 8'h5A);
    ack_en <= 1'b0;
    seg(8'h02);
    fin(8'h03, 8'h0A);
    reading <= 1'b1;
    rd_byte <= 8'h5B;
    wr(`TWMSC_ACK_OFS, 8'h01);
    seg(8'h04);
    chk({7'h00, ack_seen}, 8'h01);
    rchk(`TWMSC_DATA_OFS, 8'h5B);
    fin(8'h04, 8'h04);
    stretch <= 1'b1;
    rd_byte <= 8'hC3;
    seg(8'h04);
    fin(8'h04, 8'h04);
    wr(`TWMSC_ACK_OFS, 8'h00);
    rd_byte <= 8'h3C;
    seg(8'h04);
    chk({7'h00, ack_seen}, 8'h00);
    fin(8'h04, 8'h14);
    rchk(`TWMSC_DATA_OFS, 8'hC3);
    stretch <= 1'b0;
    reading <= 1'b0;
    seg(8'h08);
    fin(8'h08, 8'h01);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    for (i = 0; i < 3; i++)
    begin
      wr(`TWMSC_LIN_OFS, {4'h0, lins[i]});
      wr(`TWMSC_EXP_OFS, {4'h0, exps[i]});
      seg(8'h01);
      wr(`TWMSC_DATA_OFS, abytes[i]);
      ack_en <= 1'b1;
      n_rise = 0;
      seg(8'h02);
      chk(got_byte, abytes[i]);
      chk_t(t9 - t1, time'(8000 * (lins[i] + 1) * (1 << exps[i]) / 12));
      seg(8'h08);
    end
    wrap_up();
  end
endmodule : twmsc_ctrl_test
